// ==== logic/mcuorg_core.sv ====
// Purpose: Program, data and stack space organisation between CPU core and program array.
// Assumes: Array answers pm_rdata the cycle after pm_rd; core stalls on fetch_grant low.
// Notes: Every read answers two cycles after its request, whatever space it hits.
//
// Function
// - Program, data, stack spaces never alias.
// - Six nested levels for calls and interrupts.
// - Twelve-bit program counter addresses 4K bytes.
// - Program space holds code, operands, test, vectors.
// - Protection refuses every external array read.
// - Protection clears with full erase, or at reset with rop_option low.
// - Constants read from the program array itself.
// - 64-byte window of array inside data.
// - Data space decodes RAM, CPU, peripheral registers.
// - High programming pin at reset enters programming.
// - Each stack level holds twelve bits.
// - Window at 40h-7Fh over whole array.
// - Write-only window select, bits 5:0 used.
`default_nettype none

module mcuorg_core
    import mcuorg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic vpp_high,
    input wire logic rop_option,
    input wire logic pc_inc,
    input wire logic pc_jump,
    input wire logic pc_call,
    input wire logic pc_ret,
    input wire logic irq_enter,
    input wire logic [mcuorg_pkg::PC_W-1:0] pc_target,
    output logic [mcuorg_pkg::PC_W-1:0] program_counter,
    output logic [2:0] stack_depth,
    input wire logic fetch_req,
    output logic fetch_grant,
    output logic [7:0] fetch_data,
    output logic fetch_valid,
    input wire logic [7:0] data_addr,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic [7:0] data_wdata,
    output logic [7:0] data_rdata,
    output logic data_rvalid,
    output logic periph_sel,
    output logic periph_wr,
    output logic [7:0] periph_addr,
    output logic [7:0] periph_wdata,
    input wire logic [7:0] periph_rdata,
    output logic [7:0] ior_value,
    input wire logic ext_rd,
    input wire logic [mcuorg_pkg::PC_W-1:0] ext_addr,
    input wire logic ext_erase,
    input wire logic ext_protect_set,
    output logic [7:0] ext_rdata,
    output logic ext_rvalid,
    output logic ext_refused,
    output logic [mcuorg_pkg::PC_W-1:0] pm_addr,
    output logic pm_rd,
    input wire logic [7:0] pm_rdata,
    output logic pm_erase,
    output logic prog_mode,
    output logic read_protected
);
    import mcuorg_pkg::*;

    typedef struct packed {
        logic [PC_W-1:0] pc;
        logic [WSEL_W-1:0] wsel;
        logic [7:0] acc;
        logic [3:0][7:0] xyvw;
        logic [RAM_BYTES-1:0][7:0] ram;
        logic [7:0] ior;
        logic prog;
        logic protect;
        mcuorg_pend_e pend;
        logic pend_win;
        logic [7:0] stage;
        logic [7:0] data_rdata;
        logic data_rvalid;
        logic [7:0] fetch_data;
        logic fetch_valid;
        logic [7:0] ext_rdata;
        logic ext_rvalid;
        logic ext_refused;
        logic refuse_pend;
        logic pm_erase;
    } mcuorg_state_s;

    mcuorg_state_s s_q;
    mcuorg_state_s s_d;

    logic run;
    logic in_win;
    logic in_xyvw;
    logic in_ram;
    logic in_periph;
    logic win_rd;
    logic ext_ok;
    logic ext_bad;
    logic push;
    logic pop;
    logic [PC_W-1:0] stack_top;
    logic [7:0] reg_rd;
    logic [5:0] ram_idx;

    assign run = !s_q.prog;

    // Data-space decode; stack has no data address at all
    assign in_win = data_addr >= WIN_BASE && data_addr <= WIN_LAST;
    assign in_xyvw = data_addr >= XYVW_BASE && data_addr <= XYVW_LAST;
    assign in_ram = data_addr >= RAM_BASE && data_addr <= RAM_LAST;
    assign in_periph = data_addr >= PERIPH_BASE && data_addr <= PERIPH_LAST
        && data_addr != IOR_ADDR && data_addr != WSEL_ADDR && !in_ram;
    assign ram_idx = 6'(data_addr - RAM_BASE);

    // Window reads go to the array, never to separate storage
    assign win_rd = run && data_rd && in_win;

    // External reads: programming mode only, refused when protected
    assign ext_bad = s_q.protect || (ext_addr >= TEST_BASE && ext_addr <= TEST_LAST);
    assign ext_ok = s_q.prog && ext_rd && !ext_bad;

    // Protection plays no part in the core's own paths
    // Any data read owns the answer slot, so a fetch waits a cycle
    assign fetch_grant = run && fetch_req && !data_rd;
    assign pm_rd = win_rd || fetch_grant || ext_ok;

    always_comb begin
        if (win_rd) begin
            pm_addr = {s_q.wsel, data_addr[WIN_OFS_W-1:0]};
        end else if (ext_ok) begin
            pm_addr = ext_addr;
        end else begin
            pm_addr = s_q.pc;
        end
    end

    // Peripheral registers sit outside; strobes pass straight through
    assign periph_sel = run && (data_rd || data_wr) && in_periph;
    assign periph_wr = run && data_wr && in_periph;
    assign periph_addr = data_addr;
    assign periph_wdata = data_wdata;

    // Stack pushes for both calls and interrupt entries
    assign push = run && (irq_enter || pc_call);
    assign pop = run && !push && !pc_jump && pc_ret;

    mcuorg_stack u_stack (
        .clk(clk),
        .rst(rst),
        .push(push),
        .pop(pop),
        .push_addr(s_q.pc),
        .top(stack_top),
        .depth(stack_depth)
    );

    // Readable data-space locations; write-only and reserved read as zero
    always_comb begin
        reg_rd = RD_ZERO;
        if (in_ram) begin
            reg_rd = s_q.ram[ram_idx];
        end else if (in_xyvw) begin
            reg_rd = s_q.xyvw[data_addr[1:0]];
        end else if (data_addr == ACC_ADDR) begin
            reg_rd = s_q.acc;
        end else if (in_periph) begin
            reg_rd = periph_rdata;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.data_rvalid = 1'b0;
        s_d.fetch_valid = 1'b0;
        s_d.ext_rvalid = 1'b0;
        s_d.ext_refused = s_q.refuse_pend;
        s_d.refuse_pend = 1'b0;
        s_d.pm_erase = 1'b0;
        s_d.pend_win = 1'b0;

        // Second stage: hand the answer back to its requester
        unique case (s_q.pend)
            MCUORG_PEND_FETCH: begin
                s_d.fetch_data = pm_rdata;
                s_d.fetch_valid = 1'b1;
            end
            MCUORG_PEND_DATA: begin
                s_d.data_rdata = s_q.pend_win ? pm_rdata : s_q.stage;
                s_d.data_rvalid = 1'b1;
            end
            MCUORG_PEND_EXT: begin
                s_d.ext_rdata = pm_rdata;
                s_d.ext_rvalid = 1'b1;
            end
            MCUORG_PEND_NONE: begin
            end
        endcase

        // First stage
        s_d.pend = MCUORG_PEND_NONE;
        if (win_rd) begin
            s_d.pend = MCUORG_PEND_DATA;
            s_d.pend_win = 1'b1;
        end else if (run && data_rd) begin
            // Register reads are delayed to match window latency
            s_d.pend = MCUORG_PEND_DATA;
            s_d.stage = reg_rd;
        end
        if (fetch_grant) begin
            s_d.pend = MCUORG_PEND_FETCH;
        end else if (ext_ok) begin
            s_d.pend = MCUORG_PEND_EXT;
        end
        if (s_q.prog && ext_rd && ext_bad) begin
            s_d.refuse_pend = 1'b1;
        end

        // Data writes; window is read-only, so writes there vanish
        if (run && data_wr) begin
            if (in_ram) begin
                s_d.ram[ram_idx] = data_wdata;
            end else if (in_xyvw) begin
                s_d.xyvw[data_addr[1:0]] = data_wdata;
            end else if (data_addr == ACC_ADDR) begin
                s_d.acc = data_wdata;
            end else if (data_addr == IOR_ADDR) begin
                s_d.ior = data_wdata;
            end else if (data_addr == WSEL_ADDR) begin
                s_d.wsel = data_wdata[WSEL_W-1:0];
            end
        end

        // Program counter; wraps inside 4K
        if (run) begin
            if (irq_enter || pc_call || pc_jump) begin
                s_d.pc = pc_target;
            end else if (pc_ret) begin
                s_d.pc = stack_top;
            end else if (pc_inc) begin
                s_d.pc = s_q.pc + 12'h001;
            end
        end

        // Protection: set by option or programmer, cleared by erase or by reset with rop_option low
        if (s_q.prog && ext_protect_set) begin
            s_d.protect = 1'b1;
        end else if (ERASABLE && s_q.prog && ext_erase) begin
            s_d.protect = 1'b0;
            s_d.pm_erase = 1'b1;
        end

        // Mode and protection straps caught while reset is held
        if (rst) begin
            s_d.prog = vpp_high;
            s_d.protect = rop_option;
            s_d.pc = RESET_VEC_ADDR;
            s_d.pend = MCUORG_PEND_NONE;
            s_d.pend_win = 1'b0;
            s_d.data_rdata = RD_ZERO;
            s_d.data_rvalid = 1'b0;
            s_d.fetch_data = RD_ZERO;
            s_d.fetch_valid = 1'b0;
            s_d.ext_rdata = RD_ZERO;
            s_d.ext_rvalid = 1'b0;
            s_d.ext_refused = 1'b0;
            s_d.refuse_pend = 1'b0;
            s_d.pm_erase = 1'b0;
            s_d.ior = RD_ZERO;
            // Window select, RAM and CPU registers keep their value: undefined by design
        end
    end

    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign program_counter = s_q.pc;
    assign fetch_data = s_q.fetch_data;
    assign fetch_valid = s_q.fetch_valid;
    assign data_rdata = s_q.data_rdata;
    assign data_rvalid = s_q.data_rvalid;
    assign ext_rdata = s_q.ext_rdata;
    assign ext_rvalid = s_q.ext_rvalid;
    assign ext_refused = s_q.ext_refused;
    assign pm_erase = s_q.pm_erase;
    assign prog_mode = s_q.prog;
    assign read_protected = s_q.protect;
    assign ior_value = s_q.ior;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_win_req;
        !prog_mode && data_rd && data_addr >= WIN_BASE && data_addr <= WIN_LAST;
    endsequence

    sequence s_win_answer;
        ##1 1'b1 ##1 (data_rvalid && data_rdata == $past(pm_rdata));
    endsequence

    sequence s_refused_read;
        prog_mode && ext_rd && read_protected;
    endsequence

    a_window_addr: assert property (s_win_req |-> pm_rd && pm_addr[5:0] == data_addr[5:0])
        else $error("window read not mapped into array");
    a_window_data: assert property (s_win_req |-> s_win_answer)
        else $error("window read did not return array data");
    a_protect_block: assert property (s_refused_read |-> !pm_rd ##2 (ext_refused && !ext_rvalid))
        else $error("protected array read was not refused");
    a_protect_clear: assert property ($fell(read_protected) |-> $past(prog_mode && ext_erase) && pm_erase)
        else $error("protection cleared without full erase");
    a_fetch_addr: assert property (fetch_grant |-> pm_addr == program_counter ##2 fetch_valid)
        else $error("fetch not issued at program counter");
    a_fetch_protect: assert property (!prog_mode && fetch_req && !data_rd |-> fetch_grant)
        else $error("core fetch blocked");
    a_prog_entry: assert property ($fell(rst) |-> prog_mode == $past(vpp_high))
        else $error("programming mode not taken from reset strap");
    a_prog_hold: assert property (!$past(rst) |-> $stable(prog_mode))
        else $error("mode changed outside reset");
    a_call_return: assert property (!prog_mode && pc_call && !irq_enter ##1 (!prog_mode && pc_ret
        && !pc_call && !irq_enter && !pc_jump) |=> program_counter == $past(program_counter, 2))
        else $error("return did not restore call address");
    a_no_alias: assert property (!prog_mode && data_wr && !(pc_inc || pc_jump || pc_call || pc_ret || irq_enter)
        |=> $stable(program_counter) && $stable(stack_depth))
        else $error("data write disturbed program or stack space");
    a_periph_decode: assert property (!prog_mode && data_wr && data_addr == 8'hD0 |-> periph_sel && periph_wr)
        else $error("peripheral register not decoded");

endmodule : mcuorg_core

`default_nettype wire

// ==== logic/mcuorg_stack.sv ====
// Purpose: Six-level hardware return stack, separate from data space.
// Assumes: At most one of push or pop per cycle; push wins if both.
// Notes: Push on a full stack drops the deepest level, as the hardware does.
`default_nettype none

module mcuorg_stack
    import mcuorg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic push,
    input wire logic pop,
    input wire logic [mcuorg_pkg::PC_W-1:0] push_addr,
    output logic [mcuorg_pkg::PC_W-1:0] top,
    output logic [2:0] depth
);
    import mcuorg_pkg::*;

    typedef struct packed {
        logic [STACK_LEVELS-1:0][PC_W-1:0] levels;
        logic [2:0] depth;
    } mcuorg_stk_s;

    mcuorg_stk_s st_q;
    mcuorg_stk_s st_d;
    logic [PC_W-1:0] lvl_n [STACK_LEVELS];

    // Shift register: each level takes its neighbour
    for (genvar i = 0; i < STACK_LEVELS; i++) begin : g_lvl
        if (i == 0) begin : g_top
            assign lvl_n[i] = push ? push_addr : (pop ? st_q.levels[1] : st_q.levels[0]);
        end else if (i == STACK_LEVELS - 1) begin : g_bot
            assign lvl_n[i] = push ? st_q.levels[i-1] : st_q.levels[i];
        end else begin : g_mid
            assign lvl_n[i] = push ? st_q.levels[i-1] : (pop ? st_q.levels[i+1] : st_q.levels[i]);
        end
    end

    always_comb begin
        st_d = st_q;
        for (int i = 0; i < STACK_LEVELS; i++) begin
            st_d.levels[i] = lvl_n[i];
        end
        if (rst) begin
            st_d.depth = DEPTH_EMPTY;
        end else if (push) begin
            // Full stack stays full; deepest entry is lost
            if (st_q.depth != DEPTH_FULL) begin
                st_d.depth = st_q.depth + 3'h1;
            end
        end else if (pop && st_q.depth != DEPTH_EMPTY) begin
            st_d.depth = st_q.depth - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    assign top = st_q.levels[0];
    assign depth = st_q.depth;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_push_top: assert property (push |=> top == $past(push_addr))
        else $error("stack top is not the pushed address");
    a_depth_cap: assert property (depth <= DEPTH_FULL)
        else $error("stack depth beyond six levels");
    a_push_pop: assert property (push ##1 (pop && !push) |=> top == $past(top, 2))
        else $error("pop did not restore previous top");

endmodule : mcuorg_stack

`default_nettype wire

// ==== shared/mcuorg_pkg.sv ====
// Purpose: Shared constants and types for the memory-space organisation block.
// Assumes: 8-bit data space, 12-bit program space, one 200 MHz clock.
// Notes: Data-space decode boundaries live here so core and bench agree.
`default_nettype none

package mcuorg_pkg;

    localparam int PC_W = 12;
    localparam int STACK_LEVELS = 6;
    localparam int WSEL_W = 6;
    localparam int WIN_OFS_W = 6;
    localparam int RAM_BYTES = 64;

    // Program space
    localparam logic [11:0] PM_LAST = 12'hFFF;
    localparam logic [11:0] RESET_VEC_ADDR = 12'hFFE;
    localparam logic [11:0] TEST_BASE = 12'hF80;
    localparam logic [11:0] TEST_LAST = 12'hF9F;

    // Data space
    localparam logic [7:0] WIN_BASE = 8'h40;
    localparam logic [7:0] WIN_LAST = 8'h7F;
    localparam logic [7:0] XYVW_BASE = 8'h80;
    localparam logic [7:0] XYVW_LAST = 8'h83;
    localparam logic [7:0] RAM_BASE = 8'h84;
    localparam logic [7:0] RAM_LAST = 8'hC3;
    localparam logic [7:0] PERIPH_BASE = 8'hC0;
    localparam logic [7:0] PERIPH_LAST = 8'hFE;
    localparam logic [7:0] IOR_ADDR = 8'hC8;
    localparam logic [7:0] WSEL_ADDR = 8'hC9;
    localparam logic [7:0] ACC_ADDR = 8'hFF;

    // Values after reset, and the full stack depth
    localparam logic [7:0] RD_ZERO = 8'h00;
    localparam logic [2:0] DEPTH_EMPTY = 3'h0;
    localparam logic [2:0] DEPTH_FULL = 3'h6;

    // Program-memory read latency from request to answer, in cycles
    localparam int PM_LAT = 2;

    // Variant: 1 when the array can be fully erased
    localparam logic ERASABLE = 1'b1;

    typedef enum logic [1:0] {
        MCUORG_PEND_NONE,
        MCUORG_PEND_FETCH,
        MCUORG_PEND_DATA,
        MCUORG_PEND_EXT
    } mcuorg_pend_e;

endpackage : mcuorg_pkg

`default_nettype wire

// ==== sim/mcuorg_core_bench.sv ====
// Purpose: Self-checking bench for the memory-space organisation core.
// Assumes: Answers come one cycle after the taking edge.
// Notes: Expected values come from a queue stack model and the array formula.
`default_nettype none

module mcuorg_core_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import mcuorg_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic vpp_high = 1'b0, rop_option = 1'b0, pc_inc = 1'b0, pc_jump = 1'b0;
    logic pc_call = 1'b0, pc_ret = 1'b0, irq_enter = 1'b0, fetch_req = 1'b0;
    logic data_rd = 1'b0, data_wr = 1'b0, ext_rd = 1'b0, ext_erase = 1'b0;
    logic ext_protect_set = 1'b0;
    logic [11:0] pc_target = 12'h000, ext_addr = 12'h000, program_counter, pm_addr;
    logic [7:0] data_addr = 8'h00, data_wdata = 8'h00, periph_rdata = 8'h00;
    logic [7:0] fetch_data, data_rdata, periph_addr, periph_wdata, ior_value;
    logic [7:0] ext_rdata, pm_rdata, d;
    logic [2:0] stack_depth;
    logic fetch_grant, fetch_valid, data_rvalid, periph_sel, periph_wr;
    logic ext_rvalid, ext_refused, pm_rd, pm_erase, prog_mode, read_protected, r;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [11:0] pc_m;
    logic [11:0] stk[$];
    int dep = 0;
    bit erased = 0;
    bit prot_m = 0;
    logic [5:0] ws;
    logic [5:0] off;

    mcuorg_core DUT (.clk(clk), .rst(rst), .vpp_high(vpp_high), .rop_option(rop_option),
        .pc_inc(pc_inc), .pc_jump(pc_jump), .pc_call(pc_call), .pc_ret(pc_ret),
        .irq_enter(irq_enter), .pc_target(pc_target), .program_counter(program_counter),
        .stack_depth(stack_depth), .fetch_req(fetch_req), .fetch_grant(fetch_grant),
        .fetch_data(fetch_data), .fetch_valid(fetch_valid), .data_addr(data_addr),
        .data_rd(data_rd), .data_wr(data_wr), .data_wdata(data_wdata),
        .data_rdata(data_rdata), .data_rvalid(data_rvalid), .periph_sel(periph_sel),
        .periph_wr(periph_wr), .periph_addr(periph_addr), .periph_wdata(periph_wdata),
        .periph_rdata(periph_rdata), .ior_value(ior_value), .ext_rd(ext_rd),
        .ext_addr(ext_addr), .ext_erase(ext_erase), .ext_protect_set(ext_protect_set),
        .ext_rdata(ext_rdata), .ext_rvalid(ext_rvalid), .ext_refused(ext_refused),
        .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_rdata(pm_rdata), .pm_erase(pm_erase),
        .prog_mode(prog_mode), .read_protected(read_protected));

    mcuorg_pm_model pm (.clk(clk), .pm_addr(pm_addr), .pm_rd(pm_rd),
        .pm_erase(pm_erase), .pm_rdata(pm_rdata));

    always #2.5 clk = ~clk;

    function automatic logic [7:0] mem_val(input logic [11:0] a);
        return erased ? 8'hFF : a[7:0] ^ {a[11:8], 4'h5};
    endfunction : mem_val

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude

    // Answer stands between the first and second edge after the taking edge
    task automatic get_ans(output logic [7:0] dv, output logic rf);
        tick();
        chk(16'(fetch_valid | data_rvalid | ext_rvalid | ext_refused), 16'h1);
        dv = fetch_valid ? fetch_data : data_rvalid ? data_rdata : ext_rdata;
        rf = ext_refused;
    endtask : get_ans

    task automatic do_reset(input logic vpp, input logic rop);
        rst = 1'b1;
        vpp_high = vpp;
        rop_option = rop;
        repeat (5) tick();
        rst = 1'b0;
        prot_m = rop;
        pc_m = RESET_VEC_ADDR;
        // Levels are not reset in hardware, only the depth
        dep = 0;
        chk(16'(prog_mode), 16'(vpp));
        chk(16'(read_protected), 16'(rop));
        chk(16'(program_counter), 16'(pc_m));
        chk(16'(stack_depth), 16'h0);
    endtask : do_reset

    task automatic dwrite(input logic [7:0] a, input logic [7:0] w);
        data_addr = a;
        data_wdata = w;
        data_wr = 1'b1;
        #1;
        // Only D0h is a peripheral among the addresses written here
        chk(16'({periph_sel, periph_wr}), 16'({2{a == 8'hD0}}));
        chk(16'({periph_addr, periph_wdata}), {a, w});
        tick();
        data_wr = 1'b0;
        tick();
    endtask : dwrite

    task automatic dread(input logic [7:0] a, output logic [7:0] dv);
        logic rf;
        data_addr = a;
        data_rd = 1'b1;
        tick();
        data_rd = 1'b0;
        get_ans(dv, rf);
    endtask : dread

    task automatic fetch();
        logic rf;
        logic [7:0] dv;
        {irq_enter, pc_ret, pc_call, pc_jump, pc_inc} = 5'h00;
        fetch_req = 1'b1;
        #1;
        chk(16'(fetch_grant), 16'h1);
        tick();
        fetch_req = 1'b0;
        get_ans(dv, rf);
        chk(16'(dv), 16'(mem_val(pc_m)));
    endtask : fetch

    task automatic ext_chk(input logic [11:0] a);
        logic rf;
        logic [7:0] dv;
        bit no;
        no = prot_m || (a >= TEST_BASE && a <= TEST_LAST);
        ext_addr = a;
        ext_rd = 1'b1;
        tick();
        ext_rd = 1'b0;
        get_ans(dv, rf);
        chk(16'(rf), 16'(no));
        if (!no) begin
            chk(16'(dv), 16'(mem_val(a)));
        end
    endtask : ext_chk

    task automatic pc_cmd(input int k);
        pc_target = 12'($urandom);
        // Command stays up until the next command or fetch replaces it
        {irq_enter, pc_ret, pc_call, pc_jump, pc_inc} = 5'(1 << k);
        tick();
        if (k == 0) begin
            pc_m = pc_m + 12'h001;
        end else if (k == 3) begin
            // Levels shift up; the bottom one keeps its stale value
            if (stk.size() > 0) begin
                pc_m = stk[0];
                stk.push_back(stk[stk.size() - 1]);
                void'(stk.pop_front());
            end
            if (dep > 0) begin
                dep--;
            end
        end else begin
            if (k != 1) begin
                stk.push_front(pc_m);
                if (dep < STACK_LEVELS) begin
                    dep++;
                end
            end
            if (stk.size() > STACK_LEVELS) begin
                void'(stk.pop_back());
            end
            pc_m = pc_target;
        end
        chk(16'(program_counter), 16'(pc_m));
        chk(16'(stack_depth), 16'(dep));
    endtask : pc_cmd

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            conclude();
        end
    end

    initial begin
        void'($urandom(32'h831e13f0));
        do_reset(1'b0, 1'b1);
        fetch();
        for (int i = 0; i < 40; i++) begin
            pc_cmd(i < 7 ? 2 : i < 15 ? 3 : int'($urandom_range(4, 0)));
            fetch();
        end
        pc_cmd(2);
        pc_cmd(3);
        fetch();
        $display("Test stack and fetch done");
        for (int i = 0; i < 10; i++) begin
            ws = 6'($urandom);
            off = i == 0 ? 6'h00 : i == 1 ? 6'h3F : 6'($urandom);
            dwrite(WSEL_ADDR, {2'b00, ws});
            dwrite(WIN_BASE | 8'(off), 8'($urandom));
            dread(WIN_BASE | 8'(off), d);
            chk(16'(d), 16'(mem_val({ws, off})));
        end
        dread(WSEL_ADDR, d);
        chk(16'(d), 16'(RD_ZERO));
        $display("Test window done");
        dwrite(RAM_BASE, 8'hA5);
        dwrite(RAM_LAST, 8'h3C);
        dwrite(XYVW_BASE, 8'h96);
        dwrite(ACC_ADDR, 8'h69);
        dread(RAM_BASE, d);
        chk(16'(d), 16'hA5);
        dread(RAM_LAST, d);
        chk(16'(d), 16'h3C);
        dread(XYVW_BASE, d);
        chk(16'(d), 16'h96);
        dread(ACC_ADDR, d);
        chk(16'(d), 16'h69);
        dwrite(IOR_ADDR, 8'h5A);
        chk(16'(ior_value), 16'h5A);
        periph_rdata = 8'($urandom);
        dread(8'hD0, d);
        chk(16'(d), 16'(periph_rdata));
        dwrite(8'hD0, 8'($urandom));
        $display("Test data space done");
        do_reset(1'b1, 1'b0);
        ext_chk(12'($urandom_range(3967, 0)));
        ext_chk(TEST_BASE);
        ext_chk(TEST_LAST);
        ext_chk(12'hFA0);
        ext_protect_set = 1'b1;
        tick();
        ext_protect_set = 1'b0;
        prot_m = 1;
        chk(16'(read_protected), 16'h1);
        ext_chk(12'h123);
        ext_erase = 1'b1;
        tick();
        ext_erase = 1'b0;
        chk(16'(pm_erase), 16'h1);
        tick();
        erased = 1;
        prot_m = 0;
        chk(16'(read_protected), 16'h0);
        ext_chk(12'h456);
        do_reset(1'b1, 1'b1);
        ext_chk(12'h010);
        do_reset(1'b0, 1'b0);
        fetch();
        $display("Test programming mode done");
        conclude();
    end
endmodule : mcuorg_core_bench

`default_nettype wire

// ==== sim/mcuorg_pm_model.sv ====
// Purpose: Program array model that answers the core one cycle after a read strobe.
// Assumes: Patterned content; erase fills every byte with FFh.
// Notes: A released data line shows the inverse of its last value, so the last byte read returns on every second idle cycle.
`default_nettype none

module mcuorg_pm_model
    import mcuorg_pkg::*;
(
    input wire logic clk,
    input wire logic [mcuorg_pkg::PC_W-1:0] pm_addr,
    input wire logic pm_rd,
    input wire logic pm_erase,
    output logic [7:0] pm_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [0:4095];

    initial begin
        pm_rdata = 8'h00;
        for (int a = 0; a < 4096; a++) begin
            mem[a] = 8'(a) ^ {4'(a >> 8), 4'h5};
        end
    end

    always @(posedge clk) begin
        if (pm_erase) begin
            for (int a = 0; a < 4096; a++) begin
                mem[a] <= 8'hFF;
            end
        end
        if (pm_rd) begin
            pm_rdata <= mem[pm_addr];
        end else begin
            pm_rdata <= ~pm_rdata;
        end
    end
endmodule : mcuorg_pm_model

`default_nettype wire
